/* File: rtl/bridge_win_pkg.sv */
// Constants, field layouts and carrier types for the PCI target window decoder.
package bridge_win_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] OFF_WIN4_CONTROL = 12'h01A0;
  localparam logic [11:0] OFF_WIN4_BASE    = 12'h01A4;
  localparam logic [11:0] OFF_WIN4_LIMIT   = 12'h01A8;
  localparam logic [11:0] OFF_WIN4_OFFSET  = 12'h01AC;
  localparam logic [11:0] OFF_WIN5_CONTROL = 12'h01B4;
  localparam logic [11:0] OFF_WIN5_BASE    = 12'h01B8;
  localparam logic [11:0] OFF_WIN5_LIMIT   = 12'h01BC;
  localparam logic [11:0] OFF_WIN5_OFFSET  = 12'h01C0;

  localparam int          NUM_REGS    = 8;
  localparam logic [3:0]  IDX_W4_CTL  = 4'h0;
  localparam logic [3:0]  IDX_W4_BASE = 4'h1;
  localparam logic [3:0]  IDX_W4_LIM  = 4'h2;
  localparam logic [3:0]  IDX_W4_OFF  = 4'h3;
  localparam logic [3:0]  IDX_W5_CTL  = 4'h4;
  localparam logic [3:0]  IDX_W5_BASE = 4'h5;
  localparam logic [3:0]  IDX_W5_LIM  = 4'h6;
  localparam logic [3:0]  IDX_W5_OFF  = 4'h7;
  localparam logic [3:0]  IDX_NONE    = 4'hF;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [31:0] RST_CONTROL  = 32'h0080_0000;
  localparam logic [31:0] RST_ADDR     = 32'h0000_0000;
  localparam logic [31:0] MASK_CONTROL = 32'hC0C7_5101;
  localparam logic [31:0] MASK_4K      = 32'hFFFF_F000;
  localparam logic [31:0] MASK_64K     = 32'hFFFF_0000;
  localparam int          GRAN_LSB_4K  = 12;
  localparam int          GRAN_LSB_64K = 16;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  // ****************************************************************
  // Field encodings and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    WIDTH_8  = 2'b00,
    WIDTH_16 = 2'b01,
    WIDTH_32 = 2'b10,
    WIDTH_64 = 2'b11
  } vme_width_t;

  typedef enum logic [2:0] {
    SPACE_A16   = 3'b000,
    SPACE_A24   = 3'b001,
    SPACE_A32   = 3'b010,
    SPACE_RSV3  = 3'b011,
    SPACE_RSV4  = 3'b100,
    SPACE_CFG   = 3'b101,
    SPACE_USER1 = 3'b110,
    SPACE_USER2 = 3'b111
  } vme_space_t;

  typedef struct packed {
    logic       enable;
    logic       posted_write_allow;
    logic [5:0] rsv_29_24;
    vme_width_t vme_max_width;
    logic [2:0] rsv_21_19;
    vme_space_t vme_space_select;
    logic       rsv_15;
    logic       program_data_select;
    logic       rsv_13;
    logic       privilege_select;
    logic [2:0] rsv_11_9;
    logic       block_cycle_allow;
    logic [6:0] rsv_7_1;
    logic       pci_space_select;
  } ctl_t;

  typedef struct packed {
    vme_space_t space;
    vme_width_t width;
    logic       space_reserved;
    logic       am_program;
    logic       am_supervisor;
    logic       blt_allow;
    logic       mblt_allow;
    logic       posted;
  } attr_t;

  typedef struct packed {
    logic        hit;
    logic        window;
    logic [31:0] vme_addr;
    attr_t       attr;
  } result_t;

endpackage

/* File: rtl/window_match.sv */
// Base and limit comparison and offset translation for one target window.
`timescale 1ns/1ps
module window_match #(
  parameter int GRAN_LSB = 12
) (
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  input  wire logic [31:0] limit,
  input  wire logic [31:0] offset,
  input  wire logic        enable,
  output logic             hit,
  output logic [31:0]      xlat
);
  localparam int HI_W = 32 - GRAN_LSB;

  logic [HI_W-1:0] a_hi;
  logic [HI_W-1:0] b_hi;
  logic [HI_W-1:0] l_hi;
  logic [HI_W-1:0] o_hi;
  logic [HI_W-1:0] sum_hi;

  // Only the bits above the granularity take part in any comparison.
  assign a_hi = addr[31:GRAN_LSB];
  assign b_hi = base[31:GRAN_LSB];
  assign l_hi = limit[31:GRAN_LSB];
  assign o_hi = offset[31:GRAN_LSB];

  // A zero limit removes the upper bound altogether.
  assign hit = enable && (a_hi >= b_hi) && ((l_hi == '0) || (a_hi < l_hi));

  // The carry out of the top bit is dropped, so the sum wraps like two's complement.
  assign sum_hi = a_hi + o_hi;
  assign xlat   = {sum_hi, addr[GRAN_LSB-1:0]};
endmodule

/* File: rtl/attr_resolve.sv */
// Resolves one window's control word into the VMEbus cycle attributes.
`timescale 1ns/1ps
module attr_resolve (
  input  wire bridge_win_pkg::ctl_t  ctl,
  output bridge_win_pkg::attr_t      attr
);
  logic wide_space;

  always_comb
  begin
    wide_space = (ctl.vme_space_select == bridge_win_pkg::SPACE_A24) ||
                 (ctl.vme_space_select == bridge_win_pkg::SPACE_A32);
    attr.space          = ctl.vme_space_select;
    attr.width          = ctl.vme_max_width;
    attr.space_reserved = (ctl.vme_space_select == bridge_win_pkg::SPACE_RSV3) ||
                          (ctl.vme_space_select == bridge_win_pkg::SPACE_RSV4);
    attr.am_program     = ctl.program_data_select;
    attr.am_supervisor  = ctl.privilege_select;
    attr.blt_allow      = ctl.block_cycle_allow && wide_space &&
                          (ctl.vme_max_width != bridge_win_pkg::WIDTH_64);
    attr.mblt_allow     = wide_space && (ctl.vme_max_width == bridge_win_pkg::WIDTH_64);
    // I/O windows are always coupled, whatever software asked for.
    attr.posted         = ctl.posted_write_allow && !ctl.pci_space_select;
  end
endmodule

/* File: rtl/pci_target_window_decode.sv */
// PCI target windows four and five: registers, address decode and attribute output.
//
// Functional notes
// - Base is the lowest decoded PCI address.
// - Claim when base <= address < limit.
// - Zero limit means no upper bound.
// - Window four compares bits 31 to 12.
// - Window five compares bits 31 to 16.
// - Window four adds offset to address bits 31:12.
// - Block-cycle bit counts only A24/A32, narrow widths.
// - A24/A32 at 64-bit allows multiplexed block transfers.
// - I/O windows ignore posting; always coupled.
// - Width field encodes 8/16/32/64; resets 32-bit.
// - Window-on bit off: no accesses claimed.
// - Posted-write bit: 0 forbids, 1 allows posting.
// - Program/data bit: 0 data, 1 program.
// - Privilege bit: 0 user, 1 supervisor.
`timescale 1ns/1ps
module pci_target_window_decode (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic [bridge_win_pkg::ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                                  s_axi_awvalid,
  output logic                                       s_axi_awready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  input  wire logic                                  s_axi_wvalid,
  output logic                                       s_axi_wready,
  output logic [1:0]                                 s_axi_bresp,
  output logic                                       s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  input  wire logic [bridge_win_pkg::ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                                  s_axi_arvalid,
  output logic                                       s_axi_arready,
  output logic [31:0]                                s_axi_rdata,
  output logic [1:0]                                 s_axi_rresp,
  output logic                                       s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  input  wire logic                                  req_valid,
  input  wire logic [31:0]                           req_addr,
  input  wire logic                                  req_is_io,
  input  wire logic                                  req_is_write,
  output logic                                       res_valid,
  output bridge_win_pkg::result_t                    res
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [3:0] reg_index(input logic [bridge_win_pkg::ADDR_W-1:0] a);
    logic [9:0] w;
    w = a[11:2];
    if (w == bridge_win_pkg::OFF_WIN4_CONTROL[11:2]) reg_index = bridge_win_pkg::IDX_W4_CTL;
    else if (w == bridge_win_pkg::OFF_WIN4_BASE[11:2]) reg_index = bridge_win_pkg::IDX_W4_BASE;
    else if (w == bridge_win_pkg::OFF_WIN4_LIMIT[11:2]) reg_index = bridge_win_pkg::IDX_W4_LIM;
    else if (w == bridge_win_pkg::OFF_WIN4_OFFSET[11:2]) reg_index = bridge_win_pkg::IDX_W4_OFF;
    else if (w == bridge_win_pkg::OFF_WIN5_CONTROL[11:2]) reg_index = bridge_win_pkg::IDX_W5_CTL;
    else if (w == bridge_win_pkg::OFF_WIN5_BASE[11:2]) reg_index = bridge_win_pkg::IDX_W5_BASE;
    else if (w == bridge_win_pkg::OFF_WIN5_LIMIT[11:2]) reg_index = bridge_win_pkg::IDX_W5_LIM;
    else if (w == bridge_win_pkg::OFF_WIN5_OFFSET[11:2]) reg_index = bridge_win_pkg::IDX_W5_OFF;
    else reg_index = bridge_win_pkg::IDX_NONE;
  endfunction

  // Reserved bits are held at zero by the mask, so they always read back as zero.
  function automatic logic [31:0] reg_mask(input logic [3:0] idx);
    if (idx == bridge_win_pkg::IDX_W4_CTL || idx == bridge_win_pkg::IDX_W5_CTL)
      reg_mask = bridge_win_pkg::MASK_CONTROL;
    else if (idx <= bridge_win_pkg::IDX_W4_OFF)
      reg_mask = bridge_win_pkg::MASK_4K;
    else
      reg_mask = bridge_win_pkg::MASK_64K;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb,
                                        input logic [31:0] mask);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        m[b*8 +: 8] = new_v[b*8 +: 8];
    end
    merge = m & mask;
  endfunction

  // ****************************************************************
  // AXI4-Lite slave and register file
  // ****************************************************************
  logic [31:0]                       regs_r [bridge_win_pkg::NUM_REGS];
  logic [31:0]                       regs_nxt [bridge_win_pkg::NUM_REGS];
  logic                              aw_held_r;
  logic                              aw_held_nxt;
  logic [bridge_win_pkg::ADDR_W-1:0] aw_addr_r;
  logic [bridge_win_pkg::ADDR_W-1:0] aw_addr_nxt;
  logic                              w_held_r;
  logic                              w_held_nxt;
  logic [31:0]                       w_data_r;
  logic [31:0]                       w_data_nxt;
  logic [3:0]                        w_strb_r;
  logic [3:0]                        w_strb_nxt;
  logic                              bvalid_r;
  logic                              bvalid_nxt;
  logic [1:0]                        bresp_r;
  logic [1:0]                        bresp_nxt;
  logic                              rvalid_r;
  logic                              rvalid_nxt;
  logic [31:0]                       rdata_r;
  logic [31:0]                       rdata_nxt;
  logic [1:0]                        rresp_r;
  logic [1:0]                        rresp_nxt;
  logic [3:0]                        wr_idx;
  logic [3:0]                        rd_idx;

  // A new write is refused until the previous response is accepted.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wr_idx        = reg_index(aw_addr_r);
  assign rd_idx        = reg_index(s_axi_araddr);

  always_comb
  begin
    regs_nxt    = regs_r;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    if (aw_held_r && w_held_r && !bvalid_r)
    begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      if (wr_idx == bridge_win_pkg::IDX_NONE)
        bresp_nxt = bridge_win_pkg::RESP_SLVERR;
      else
      begin
        bresp_nxt        = bridge_win_pkg::RESP_OKAY;
        regs_nxt[wr_idx[2:0]] = merge(regs_r[wr_idx[2:0]], w_data_r, w_strb_r,
                                      reg_mask(wr_idx));
      end
    end
    else if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      if (rd_idx == bridge_win_pkg::IDX_NONE)
      begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = bridge_win_pkg::RESP_SLVERR;
      end
      else
      begin
        rdata_nxt = regs_r[rd_idx[2:0]];
        rresp_nxt = bridge_win_pkg::RESP_OKAY;
      end
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < bridge_win_pkg::NUM_REGS; i++)
      begin
        regs_r[i] <= bridge_win_pkg::RST_ADDR;
      end
      regs_r[bridge_win_pkg::IDX_W4_CTL[2:0]] <= bridge_win_pkg::RST_CONTROL;
      regs_r[bridge_win_pkg::IDX_W5_CTL[2:0]] <= bridge_win_pkg::RST_CONTROL;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= bridge_win_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= bridge_win_pkg::RESP_OKAY;
    end
    else
    begin
      regs_r    <= regs_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r  <= w_held_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ****************************************************************
  // Window decode
  // ****************************************************************
  bridge_win_pkg::ctl_t    ctl4;
  bridge_win_pkg::ctl_t    ctl5;
  bridge_win_pkg::attr_t   attr4;
  bridge_win_pkg::attr_t   attr5;
  bridge_win_pkg::result_t res_r;
  bridge_win_pkg::result_t res_nxt;
  logic                    res_valid_r;
  logic                    res_valid_nxt;
  logic                    hit4;
  logic                    hit5;
  logic [31:0]             xlat4;
  logic [31:0]             xlat5;
  logic                    claim4;
  logic                    claim5;

  assign ctl4 = bridge_win_pkg::ctl_t'(regs_r[bridge_win_pkg::IDX_W4_CTL[2:0]]);
  assign ctl5 = bridge_win_pkg::ctl_t'(regs_r[bridge_win_pkg::IDX_W5_CTL[2:0]]);

  window_match #(.GRAN_LSB(bridge_win_pkg::GRAN_LSB_4K)) u_match4 (
    .addr   (req_addr),
    .base   (regs_r[bridge_win_pkg::IDX_W4_BASE[2:0]]),
    .limit  (regs_r[bridge_win_pkg::IDX_W4_LIM[2:0]]),
    .offset (regs_r[bridge_win_pkg::IDX_W4_OFF[2:0]]),
    .enable (ctl4.enable),
    .hit    (hit4),
    .xlat   (xlat4)
  );

  window_match #(.GRAN_LSB(bridge_win_pkg::GRAN_LSB_64K)) u_match5 (
    .addr   (req_addr),
    .base   (regs_r[bridge_win_pkg::IDX_W5_BASE[2:0]]),
    .limit  (regs_r[bridge_win_pkg::IDX_W5_LIM[2:0]]),
    .offset (regs_r[bridge_win_pkg::IDX_W5_OFF[2:0]]),
    .enable (ctl5.enable),
    .hit    (hit5),
    .xlat   (xlat5)
  );

  attr_resolve u_attr4 (
    .ctl  (ctl4),
    .attr (attr4)
  );

  attr_resolve u_attr5 (
    .ctl  (ctl5),
    .attr (attr5)
  );

  // A window only answers accesses in the PCI space it is mapped to.
  assign claim4 = hit4 && (ctl4.pci_space_select == req_is_io);
  assign claim5 = hit5 && (ctl5.pci_space_select == req_is_io);

  // Overlapping windows are a software error; window four wins so the answer stays defined.
  always_comb
  begin
    res_valid_nxt = req_valid;
    res_nxt       = '0;
    if (req_valid && claim4)
    begin
      res_nxt.hit         = 1'b1;
      res_nxt.window      = 1'b0;
      res_nxt.vme_addr    = xlat4;
      res_nxt.attr        = attr4;
      res_nxt.attr.posted = attr4.posted && req_is_write;
    end
    else if (req_valid && claim5)
    begin
      res_nxt.hit         = 1'b1;
      res_nxt.window      = 1'b1;
      res_nxt.vme_addr    = xlat5;
      res_nxt.attr        = attr5;
      res_nxt.attr.posted = attr5.posted && req_is_write;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      res_valid_r <= 1'b0;
      res_r       <= '0;
    end
    else
    begin
      res_valid_r <= res_valid_nxt;
      res_r       <= res_nxt;
    end
  end

  assign res_valid = res_valid_r;
  assign res       = res_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic hit4_out;
  logic hit5_out;
  assign hit4_out = res_valid_r && res_r.hit && !res_r.window;
  assign hit5_out = res_valid_r && res_r.hit && res_r.window;

  base_floor_a: assert property (hit4_out |->
    $past(req_addr[31:12]) >= $past(regs_r[1][31:12]))
    else $error("window four claimed an address below its base");
  limit_ceiling_a: assert property ((hit4_out && $past(regs_r[2][31:12]) != 20'h0_0000) |->
    $past(req_addr[31:12]) < $past(regs_r[2][31:12]))
    else $error("window four claimed an address at or above its limit");
  open_limit_a: assert property ((req_valid && ctl4.enable &&
    regs_r[2][31:12] == 20'h0_0000 && req_addr[31:12] >= regs_r[1][31:12] &&
    ctl4.pci_space_select == req_is_io) |=> hit4_out)
    else $error("zero limit did not claim an address above base");
  fine_grain_a: assert property (hit4_out |->
    res_r.vme_addr[11:0] == $past(req_addr[11:0]))
    else $error("window four altered address bits below 12");
  coarse_grain_a: assert property (hit5_out |->
    res_r.vme_addr[15:0] == $past(req_addr[15:0]))
    else $error("window five altered address bits below 16");
  offset_sum_a: assert property (hit4_out |-> res_r.vme_addr[31:12] ==
    20'($past(req_addr[31:12]) + $past(regs_r[3][31:12])))
    else $error("window four translation sum is wrong");
  blt_gate_a: assert property (hit4_out |-> res_r.attr.blt_allow ==
    ($past(ctl4.block_cycle_allow) && $past(ctl4.vme_max_width) != 2'b11 &&
     ($past(ctl4.vme_space_select) == 3'b001 || $past(ctl4.vme_space_select) == 3'b010)))
    else $error("block cycle permission applied wrongly");
  mblt_wide_a: assert property (hit4_out |-> res_r.attr.mblt_allow ==
    ($past(ctl4.vme_max_width) == 2'b11 &&
     ($past(ctl4.vme_space_select) == 3'b001 || $past(ctl4.vme_space_select) == 3'b010)))
    else $error("multiplexed block permission applied wrongly");
  io_coupled_a: assert property ((res_valid_r && res_r.hit && $past(req_is_io)) |->
    !res_r.attr.posted)
    else $error("an I/O access was marked posted");
  width_reset_a: assert property (!$past(aresetn) |->
    ctl4.vme_max_width == 2'b10 && ctl5.vme_max_width == 2'b10)
    else $error("maximum width did not reset to 32-bit");
  off_silent_a: assert property ((!ctl4.enable && !ctl5.enable) |=>
    !res_r.hit)
    else $error("a disabled window claimed an access");
  am_bits_a: assert property (hit4_out |->
    res_r.attr.am_program == $past(ctl4.program_data_select) &&
    res_r.attr.am_supervisor == $past(ctl4.privilege_select))
    else $error("address modifier selects do not follow control");
  resp_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  hit4_c: cover property (hit4_out);
  hit5_c: cover property (hit5_out);
  mblt_c: cover property (res_valid_r && res_r.attr.mblt_allow);
  write_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: verif/pci_master_model.sv */
// Behavioural PCI master that offers one decode request at a time.
`timescale 1ns/1ps
module pci_master_model (
  input  wire logic                    aclk,
  input  wire logic                    res_valid,
  input  wire bridge_win_pkg::result_t res,
  output logic                         req_valid,
  output logic [31:0]                  req_addr,
  output logic                         req_is_io,
  output logic                         req_is_write
);
  initial
    {req_valid, req_addr, req_is_io, req_is_write} = '0;

  task automatic issue(input logic [31:0] a, input logic io, input logic wr,
                       output logic v, output bridge_win_pkg::result_t r);
    @(posedge aclk);
    {req_valid, req_addr, req_is_io, req_is_write} <= {1'b1, a, io, wr};
    @(posedge aclk);
    // Inverted lines after a request so a stale address can never pass as valid.
    {req_valid, req_addr, req_is_io, req_is_write} <= {1'b0, ~a, ~io, ~wr};
    #1;
    v = res_valid;
    r = res;
  endtask
endmodule

/* File: verif/pci_target_window_decode_bench.sv */
// Self-checking bench for the PCI target window decoder.
`timescale 1ns/1ps
module pci_target_window_decode_bench;
  logic [11:0]             s_axi_awaddr, s_axi_araddr;
  logic [31:0]             s_axi_wdata, s_axi_rdata, req_addr, ctl4, b4, l4, o4, rv;
  logic [3:0]              s_axi_wstrb;
  logic [1:0]              s_axi_bresp, s_axi_rresp;
  logic                    aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                    s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic                    s_axi_arready, s_axi_rvalid, s_axi_rready, req_valid;
  logic                    req_is_io, req_is_write, res_valid, v5;
  bridge_win_pkg::result_t res, r5;
  int                      fail_count, n_compared, seed;
  logic [31:0]             edge_addr [4] = '{32'h1234_4FFF, 32'h1234_5000, 32'h1234_8FFF,
                                             32'h1234_9000};

  pci_target_window_decode i_dut (.*);
  pci_master_model         i_pci (.*);

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timed_out;
    fail_count++;
    give_verdict();
  endtask

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic chk_res(input bridge_win_pkg::result_t e, input logic v,
                         input bridge_win_pkg::result_t g);
    n_compared++;
    if ({v, g} !== {1'b1, e})
    begin
      $display("CHECK FAILED res expected %h seen %h valid %b", e, g, v);
      fail_count++;
    end
  endtask

  function automatic bridge_win_pkg::result_t exp_res(logic [31:0] a, logic io, logic wr);
    logic [2:0] sp;
    logic [1:0] w;
    logic       ab;
    sp = ctl4[18:16];
    w = ctl4[23:22];
    ab = (sp == 3'b001) || (sp == 3'b010);
    if (!(ctl4[31] && ctl4[0] == io && a[31:12] >= b4[31:12]
          && (l4[31:12] == 20'h0_0000 || a[31:12] < l4[31:12])))
      return '0;
    return {2'b10, a[31:12] + o4[31:12], a[11:0], sp, w, sp == 3'b011 || sp == 3'b100,
            ctl4[14], ctl4[12], ab && ctl4[8] && w != 2'b11, ab && w == 2'b11,
            ctl4[30] && !ctl4[0] && wr};
  endfunction

  task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    for (int n = 0; n < 40 && !got; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      got = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    if (!got) timed_out();
    chk32("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    for (int n = 0; n < 40 && !got; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      got = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    if (!got) timed_out();
    chk32("rdata", e, s_axi_rdata);
    chk32("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask

  task automatic set4(input logic [31:0] c, input logic [31:0] b, input logic [31:0] o);
    wr_chk(12'h1A0, c, 2'b00);
    wr_chk(12'h1A4, b, 2'b00);
    wr_chk(12'h1AC, o, 2'b00);
    {ctl4, b4, o4} = {c & bridge_win_pkg::MASK_CONTROL, b, o};
  endtask

  task automatic dec_chk(input logic [31:0] a, input logic io, input logic wr);
    logic                    v;
    bridge_win_pkg::result_t r;
    i_pci.issue(a, io, wr, v, r);
    chk_res(exp_res(a, io, wr), v, r);
  endtask

  initial
  begin
    seed = 31923;
    fail_count = 0;
    n_compared = 0;
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(12'h1A0, 32'h0080_0000, 2'b00);
    rd_chk(12'h1B4, 32'h0080_0000, 2'b00);
    rd_chk(12'h1B0, 32'h0000_0000, 2'b10);
    wr_chk(12'h1B0, 32'hFFFF_FFFF, 2'b10);
    wr_chk(12'h1B8, 32'hFFFF_FFFF, 2'b00);
    rd_chk(12'h1B8, 32'hFFFF_0000, 2'b00);
    wr_chk(12'h1A8, 32'h1234_9ABC, 2'b00);
    rd_chk(12'h1A8, 32'h1234_9000, 2'b00);
    l4 = 32'h1234_9000;
    set4(32'h8000_0000, 32'h1234_5000, 32'hF000_3000);
    foreach (edge_addr[i]) dec_chk(edge_addr[i], 1'b0, 1'b1);
    for (int k = 0; k < 60; k++)
    begin
      rv = $random(seed);
      set4(rv, 32'h1234_5000, $random(seed));
      rd_chk(12'h1A0, ctl4, 2'b00);
      if (k == 30) wr_chk(12'h1A8, 32'h0000_0000, 2'b00);
      if (k == 30) l4 = 32'h0000_0000;
      dec_chk(32'h1234_2000 + (32'($random(seed)) & 32'h0000_7FFF), rv[1], rv[2]);
      dec_chk(32'hFFFF_FFFF, rv[0], rv[3]);
    end
    // A reset in mid-run clears window four, so window five is then tried on its own.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(12'h1A0, 32'h0080_0000, 2'b00);
    wr_chk(12'h1B4, 32'h8080_0000, 2'b00);
    wr_chk(12'h1B8, 32'hFFFF_0000, 2'b00);
    wr_chk(12'h1C0, 32'h0001_2345, 2'b00);
    i_pci.issue(32'hFFFF_ABCD, 1'b0, 1'b1, v5, r5);
    chk32("win5 vme_addr", 32'h0000_ABCD, r5.vme_addr);
    chk32("win5 claim", 32'h0000_0007, {29'h0, v5, r5.hit, r5.window});
    i_pci.issue(32'hFFFE_FFFF, 1'b0, 1'b1, v5, r5);
    chk32("win5 below base", 32'h0000_0004, {29'h0, v5, r5.hit, r5.window});
    give_verdict();
  end
endmodule
